// File: test/jsc_tester.sv
module jsc_tester (
   output logic tck,
   output logic tms,
   output logic tdi,
   input wire tdo,
   input wire tdo_oe
);
   timeunit 1ns;
   timeprecision 1ns;
   logic oe_seen;
   // Link clock rests low between frames
   initial begin
      tck = 1'b0;
      tms = 1'b1;
      tdi = 1'b0;
      oe_seen = 1'b0;
   end
   // One 800 ns period; data out is taken late in the high phase, well clear of its update
   task automatic tick(input logic m, input logic d, output logic q);
      tms = m;
      tdi = d;
      #400 tck = 1'b1;
      oe_seen = oe_seen | tdo_oe;
      #399 q = tdo;
      #1 tck = 1'b0;
   endtask
   // Back to idle from any state
   task automatic home;
      logic q;
      repeat (5) tick(1'b1, 1'b0, q);
      tick(1'b0, 1'b0, q);
   endtask
   // Capture, shift and update one register, first bit in and out first
   task automatic scan(input logic ir, input int n, input logic [99:0] din,
      output logic [99:0] dout);
      logic q;
      int i;
      dout = '0;
      oe_seen = 1'b0;
      tick(1'b1, 1'b0, q);
      if (ir) tick(1'b1, 1'b0, q);
      tick(1'b0, 1'b0, q);
      tick(1'b0, 1'b0, q);
      for (i = 0; i < n; i++) begin
         tick(i == n - 1, din[i], q);
         dout[i] = q;
      end
      tick(1'b1, 1'b0, q);
      tick(1'b0, 1'b0, q);
   endtask
endmodule // jsc_tester

// File: test/jsc_top_properties.sv
`include "jsc_defs.vh"
module jsc_top_properties (
   input wire hclk,
   input wire hresetn,
   input wire hsel,
   input wire [31:0] haddr,
   input wire [1:0] htrans,
   input wire hwrite,
   input wire [31:0] hwdata,
   input wire hready,
   input wire hreadyout,
   input wire hresp,
   input wire [31:0] hrdata,
   input wire irq,
   input wire test_port_enable_fuse,
   input wire tdo_oe,
   input wire device_reset_req
);
   reg ph_wr, ph_rd, arm, arm_v, tpd_m, pud_m, flag_m;
   reg [7:0] ph_idx;
   reg [2:0] age;
   reg [1:0] lo_m, sts_m, en_m;
   wire take = hsel & hready & htrans[1];
   wire [7:0] widx = ph_wr ? ph_idx : 8'hFF;
   wire [7:0] ridx = ph_rd ? ph_idx : 8'hFF;
   wire hit = widx == `JSC_IDX_CTRL && arm && age <= 3'h4 && arm_v == hwdata[7];
   wire mapped = ph_idx == `JSC_IDX_CTRL || ph_idx == `JSC_IDX_RSTS ||
      ph_idx == `JSC_IDX_IRQ_STS || ph_idx == `JSC_IDX_IRQ_EN;
   // Reference copy of the registers, fed from each data phase
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ph_wr <= 1'b0;
         ph_rd <= 1'b0;
         ph_idx <= 8'h00;
         arm <= 1'b0;
         arm_v <= 1'b0;
         age <= 3'h7;
         tpd_m <= 1'b0;
         pud_m <= 1'b0;
         lo_m <= 2'h0;
         flag_m <= 1'b0;
         sts_m <= 2'h0;
         en_m <= 2'h0;
      end else begin
         ph_wr <= take & hwrite;
         ph_rd <= take & ~hwrite;
         ph_idx <= haddr[9:2];
         age <= (age == 3'h7) ? age : age + 3'h1;
         // A set in the same cycle beats a written zero
         flag_m <= device_reset_req | (flag_m & ~(widx == `JSC_IDX_RSTS && !hwdata[4]));
         sts_m <= (sts_m & ~((widx == `JSC_IDX_IRQ_CLR) ? hwdata[1:0] : 2'h0)) |
            {hit && hwdata[7] != tpd_m, device_reset_req};
         if (widx == `JSC_IDX_IRQ_EN) en_m <= hwdata[1:0];
         if (widx == `JSC_IDX_CTRL) begin
            lo_m <= hwdata[1:0];
            pud_m <= hwdata[4];
            arm <= !hit;
            arm_v <= hwdata[7];
            age <= 3'h1;
         end
         if (hit) tpd_m <= hwdata[7];
      end
   end
   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);
   a_bus_okay: assert property (hreadyout && !hresp)
      else $error("bus answer not ready and okay");
   a_fuse_quiet: assert property (!test_port_enable_fuse [*3] |-> !tdo_oe && !device_reset_req)
      else $error("test port active with fuse off");
   a_port_off: assert property (tpd_m [*2] |-> !tdo_oe && !device_reset_req)
      else $error("test port active while disabled");
   a_ctrl_read: assert property (ridx == `JSC_IDX_CTRL |->
      hrdata == {24'h0, tpd_m, 2'h0, pud_m, 2'h0, lo_m})
      else $error("control read differs from timed write model");
   a_flag_read: assert property (ridx == `JSC_IDX_RSTS |-> hrdata[4] == flag_m)
      else $error("reset flag read wrong");
   a_irq_level: assert property (irq == |(sts_m & en_m))
      else $error("irq level wrong");
   a_sts_read: assert property (ridx == `JSC_IDX_IRQ_STS |-> hrdata == {30'h0, sts_m})
      else $error("irq status read wrong");
   a_en_read: assert property (ridx == `JSC_IDX_IRQ_EN |-> hrdata == {30'h0, en_m})
      else $error("irq enable read wrong");
   a_unmapped_zero: assert property (ph_rd && !mapped |-> hrdata == 32'h0)
      else $error("unmapped read not zero");
   c_commit: cover property (hit);
   c_dev_reset: cover property ($rose(device_reset_req));
   c_irq: cover property ($rose(irq));
endmodule // jsc_top_properties

bind jsc_top jsc_top_properties u_props (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
   .hwdata, .hready, .hreadyout, .hresp, .hrdata, .irq, .test_port_enable_fuse, .tdo_oe,
   .device_reset_req);

// File: test/jtag_scan_control_bench.sv
`include "jsc_defs.vh"
module jtag_scan_control_bench;
   timeunit 1ns;
   timeprecision 1ns;
   logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, fuse = 1'b1, ecp = 1'b1;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, rd;
   logic [1:0] htrans = 2'h0;
   logic [32:0] core_out = 33'h0, core_oe = 33'h0, core_pue = 33'h1FFFFFFFF;
   logic [99:0] sv, dq;
   logic [32:0] pins = 33'h0AAAA5555;
   wire hreadyout, hresp, irq, tck, tms, tdi, tdo, tdo_oe, dev_rst, epp;
   wire [31:0] hrdata;
   wire [1:0] vctl;
   wire [32:0] pin_out, pin_oe, pin_pue;
   int mismatches = 0, checks = 0;
   // Free-running bus clock
   always #50 hclk = ~hclk;
   jsc_top dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .irq(irq),
      .test_port_enable_fuse(fuse), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo),
      .tdo_oe(tdo_oe), .device_reset_req(dev_rst), .vector_ctrl(vctl), .core_out(core_out),
      .core_oe(core_oe), .core_pue(core_pue), .edge_core_pue(ecp), .pin_in(pins),
      .pin_out(pin_out), .pin_oe(pin_oe), .pin_pue(pin_pue), .edge_pin_pue(epp));
   jsc_tester tester (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe));
   task automatic complete_run;
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   task automatic chk(input string what, input logic [99:0] exp, input logic [99:0] got);
      checks++;
      if (got !== exp) begin
         mismatches++;
         $display("unexpected %s: expected %h seen %h", what, exp, got);
      end
   endtask
   // Bounded wait for the slave's ready
   task automatic wait_ready;
      int n;
      n = 0;
      @(posedge hclk);
      while (hreadyout !== 1'b1) begin
         n++;
         if (n > 50) begin
            mismatches++;
            complete_run;
         end
         @(posedge hclk);
      end
   endtask
   task automatic bus(input logic w, input logic [7:0] idx, input logic [31:0] wd);
      hsel <= 1'b1;
      htrans <= `JSC_HTRANS_NONSEQ;
      haddr <= {22'h0, idx, 2'h0};
      hwrite <= w;
      wait_ready;
      htrans <= 2'h0;
      hwdata <= wd;
      wait_ready;
      rd = hrdata;
   endtask
   task automatic put(input logic [7:0] idx, input logic [31:0] wd);
      bus(1'b1, idx, wd);
   endtask
   task automatic rdchk(input logic [7:0] idx, input logic [31:0] exp, input string what);
      bus(1'b0, idx, 32'h0);
      chk(what, exp, rd);
   endtask
   task automatic jscan(input logic ir, input int n, input logic [99:0] din);
      tester.scan(ir, n, din, dq);
      @(posedge hclk);
   endtask
   task automatic t_reset_values;
      rdchk(`JSC_IDX_CTRL, 32'h0, "control");
      rdchk(`JSC_IDX_IRQ_EN, 32'h0, "irq enable");
      rdchk(`JSC_IDX_IRQ_STS, 32'h0, "irq status");
      put(8'h10, 32'hFFFFFFFF);
      rdchk(8'h10, 32'h0, "unmapped");
      rdchk(`JSC_IDX_RSTS, 32'h0, "reset status");
      $display("test reset_values done");
   endtask
   task automatic t_fuse;
      fuse <= 1'b0;
      jscan(1'b1, `JSC_IR_W, `JSC_IR_BYPASS);
      chk("drive with fuse off", 1'b0, tester.oe_seen);
      fuse <= 1'b1;
      tester.home;
      jscan(1'b1, `JSC_IR_W, `JSC_IR_BYPASS);
      chk("drive with fuse on", 1'b1, tester.oe_seen);
      chk("instruction capture", `JSC_IR_CAPTURE, dq[3:0]);
      $display("test fuse done");
   endtask
   task automatic t_timed_disable;
      put(`JSC_IDX_CTRL, 32'h80);
      repeat (6) @(posedge hclk);
      rdchk(`JSC_IDX_CTRL, 32'h0, "lone write");
      put(`JSC_IDX_CTRL, 32'h80);
      repeat (4) @(posedge hclk);
      put(`JSC_IDX_CTRL, 32'h80);
      rdchk(`JSC_IDX_CTRL, 32'h0, "late write");
      repeat (6) @(posedge hclk);
      put(`JSC_IDX_CTRL, 32'h93);
      put(`JSC_IDX_CTRL, 32'h93);
      rdchk(`JSC_IDX_CTRL, 32'h93, "timed pair");
      chk("vector control", 2'h3, vctl);
      rdchk(`JSC_IDX_IRQ_STS, 32'h2, "change event");
      jscan(1'b1, `JSC_IR_W, `JSC_IR_DEVRST);
      chk("drive while disabled", 1'b0, tester.oe_seen);
      put(`JSC_IDX_CTRL, 32'h0);
      put(`JSC_IDX_CTRL, 32'h0);
      rdchk(`JSC_IDX_CTRL, 32'h0, "timed pair back");
      $display("test timed_disable done");
   endtask
   task automatic t_dev_reset;
      put(`JSC_IDX_IRQ_EN, 32'h3);
      put(`JSC_IDX_IRQ_CLR, 32'h3);
      tester.home;
      jscan(1'b1, `JSC_IR_W, `JSC_IR_DEVRST);
      jscan(1'b0, 1, 100'h1);
      chk("reset request", 1'b1, dev_rst);
      put(`JSC_IDX_RSTS, 32'h0);
      rdchk(`JSC_IDX_RSTS, 32'h10, "flag held by set");
      jscan(1'b0, 1, 100'h0);
      chk("reset request off", 1'b0, dev_rst);
      put(`JSC_IDX_RSTS, 32'h10);
      rdchk(`JSC_IDX_RSTS, 32'h10, "flag after one");
      put(`JSC_IDX_RSTS, 32'h0);
      rdchk(`JSC_IDX_RSTS, 32'h0, "flag after zero");
      rdchk(`JSC_IDX_IRQ_STS, 32'h1, "reset event");
      put(`JSC_IDX_IRQ_EN, 32'h2);
      @(negedge hclk) chk("irq masked", 1'b0, irq);
      put(`JSC_IDX_IRQ_EN, 32'h1);
      @(negedge hclk) chk("irq raised", 1'b1, irq);
      put(`JSC_IDX_IRQ_CLR, 32'h1);
      @(negedge hclk) chk("irq cleared", 1'b0, irq);
      // Set the flag again, then a power-on reset must clear it
      jscan(1'b0, 1, 100'h1);
      rdchk(`JSC_IDX_RSTS, 32'h10, "flag set again");
      hresetn <= 1'b0;
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      rdchk(`JSC_IDX_RSTS, 32'h0, "flag after power-on");
      tester.home;
      $display("test dev_reset done");
   endtask
   task automatic t_chain;
      int j;
      logic [32:0] eo, eoe, ep;
      logic [99:0] cap;
      for (j = 0; j < 99; j++) begin
         sv[j] = (j % 3 == 2) ? j / 3 % 2 : (j % 3 == 1) ? 1 - j / 3 % 2 : j / 6 % 2;
      end
      sv[99] = 1'b1;
      for (j = 0; j < 33; j++) begin
         eo[j] = j % 2;
         eoe[j] = 1 - j % 2;
         ep[j] = j / 2 % 2;
         cap[3 * j + 2] = pins[j];
         cap[3 * j + 1] = core_oe[j];
         cap[3 * j] = core_pue[j];
      end
      cap[99] = ecp;
      @(posedge hclk);
      jscan(1'b1, `JSC_IR_W, `JSC_IR_EXTEST);
      jscan(1'b0, 100, sv);
      chk("pin data", eo, pin_out);
      chk("pin drive", eoe, pin_oe);
      chk("pin pull-up", ep, pin_pue);
      chk("edge pull-up", 1'b1, epp);
      chk("extest capture", cap, dq);
      jscan(1'b1, `JSC_IR_W, `JSC_IR_SAMPLE);
      jscan(1'b0, 100, 100'h0);
      chk("sample capture", cap, dq);
      chk("sample keeps core drive", 33'h0, pin_oe);
      jscan(1'b1, `JSC_IR_W, `JSC_IR_BYPASS);
      core_out <= 33'h012345678;
      @(negedge hclk) chk("core data", 33'h012345678, pin_out);
      put(`JSC_IDX_CTRL, 32'h10);
      @(negedge hclk) chk("pull-up gate", 33'h0, pin_pue);
      $display("test chain done");
   endtask
   // Reset, then each scenario in turn
   initial begin
      repeat (16) @(posedge hclk);
      hresetn <= 1'b1;
      t_reset_values;
      t_fuse;
      t_timed_disable;
      t_dev_reset;
      t_chain;
      complete_run;
   end
endmodule // jtag_scan_control_bench

// File: verilog/jsc_defs.vh
`ifndef JSC_DEFS_VH
`define JSC_DEFS_VH

// Register indices; the byte address is four times the index
`define JSC_IDX_W 8
`define JSC_IDX_CTRL 8'h35
`define JSC_IDX_RSTS 8'h36
`define JSC_IDX_IRQ_STS 8'h38
`define JSC_IDX_IRQ_EN 8'h39
`define JSC_IDX_IRQ_CLR 8'h3A

// Field positions
`define JSC_CTRL_TPD 7
`define JSC_CTRL_PUD 4
`define JSC_CTRL_IVSEL 1
`define JSC_CTRL_IVCE 0
`define JSC_RSTS_TPRF 4
`define JSC_IRQ_TPRF 0
`define JSC_IRQ_TPD_CHG 1

// Reset values
`define JSC_CTRL_RST 8'h00
`define JSC_CTRL_TPD_RST 1'b0
`define JSC_IRQ_W 2
`define JSC_IRQ_RST 2'h0

// Timed write window for the port-disable bit, in clock cycles
`define JSC_TIMED_WIN 3'h4
`define JSC_WIN_CNT_W 3

// AHB encodings
`define JSC_HTRANS_NONSEQ 2'h2
`define JSC_HTRANS_SEQ 2'h3

// Test port instruction codes
`define JSC_IR_W 4
`define JSC_IR_EXTEST 4'h0
`define JSC_IR_SAMPLE 4'h2
`define JSC_IR_DEVRST 4'hC
`define JSC_IR_BYPASS 4'hF
`define JSC_IR_CAPTURE 4'h1

// Chain geometry
`define JSC_CELLS_PER_PIN 3
`define JSC_CELL_DATA 2
`define JSC_CELL_CTRL 1
`define JSC_CELL_PUE 0

`endif

// File: verilog/jsc_scan_chain.v
// Boundary-scan data register: capture, shift toward bit 0, update
module jsc_scan_chain #(
   parameter LEN = 100
) (
   input wire clk,
   input wire rst_n,
   input wire capture_en,
   input wire shift_en,
   input wire update_en,
   input wire si,
   input wire [LEN-1:0] par_in,
   output wire so,
   output reg [LEN-1:0] par_out
);
   reg [LEN-1:0] chain_r;

   assign so = chain_r[0];

   // Shift stage; capture has priority over shift
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         chain_r <= {LEN{1'b0}};
      end else if (capture_en) begin
         chain_r <= par_in;
      end else if (shift_en) begin
         chain_r <= {si, chain_r[LEN-1:1]};
      end
   end

   // Update stage holds steady while shifting so pins do not ripple
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         par_out <= {LEN{1'b0}};
      end else if (update_en) begin
         par_out <= chain_r;
      end
   end
endmodule // jsc_scan_chain

// File: verilog/jsc_sync.v
// Two-stage synchroniser for levels from outside the clock domain
module jsc_sync #(
   parameter W = 1
) (
   input wire clk,
   input wire rst_n,
   input wire [W-1:0] d,
   output reg [W-1:0] q
);
   reg [W-1:0] meta_r;

   // First stage feeds only the second
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_r <= {W{1'b0}};
         q <= {W{1'b0}};
      end else begin
         meta_r <= d;
         q <= meta_r;
      end
   end
endmodule // jsc_sync

// File: verilog/jsc_top.v
// Our own choice: the AHB-Lite interface to the registers.
`include "jsc_defs.vh"

// Notes on behaviour
// - Disable bit zero: port follows enable fuse
// - Disable bit one: port always off
// - Disable bit changes on two matching writes within window
// - Reset instruction with one sets reset flag
// - Flag cleared by power-on or written zero
module jsc_top #(
   parameter NPINS = 33,
   parameter CHAIN_LEN = 100
) (
   input wire hclk,
   input wire hresetn,
   input wire hsel,
   input wire [31:0] haddr,
   input wire [1:0] htrans,
   input wire hwrite,
   input wire [2:0] hsize,
   input wire [31:0] hwdata,
   input wire hready,
   output wire hreadyout,
   output wire hresp,
   output reg [31:0] hrdata,
   output wire irq,
   input wire test_port_enable_fuse,
   input wire tck,
   input wire tms,
   input wire tdi,
   output reg tdo,
   output wire tdo_oe,
   output wire device_reset_req,
   output wire [1:0] vector_ctrl,
   input wire [NPINS-1:0] core_out,
   input wire [NPINS-1:0] core_oe,
   input wire [NPINS-1:0] core_pue,
   input wire edge_core_pue,
   input wire [NPINS-1:0] pin_in,
   output reg [NPINS-1:0] pin_out,
   output reg [NPINS-1:0] pin_oe,
   output reg [NPINS-1:0] pin_pue,
   output reg edge_pin_pue
);
   // Test port controller states
   localparam ST_TLR = 4'h0, ST_RTI = 4'h1, ST_SEL_DR = 4'h2, ST_CAP_DR = 4'h3;
   localparam ST_SH_DR = 4'h4, ST_EX1_DR = 4'h5, ST_PA_DR = 4'h6, ST_EX2_DR = 4'h7;
   localparam ST_UPD_DR = 4'h8, ST_SEL_IR = 4'h9, ST_CAP_IR = 4'hA, ST_SH_IR = 4'hB;
   localparam ST_EX1_IR = 4'hC, ST_PA_IR = 4'hD, ST_EX2_IR = 4'hE, ST_UPD_IR = 4'hF;

   // Standard test port state walk
   function [3:0] tap_next;
      input [3:0] s;
      input m;
      begin
         case (s)
            ST_TLR: tap_next = m ? ST_TLR : ST_RTI;
            ST_RTI: tap_next = m ? ST_SEL_DR : ST_RTI;
            ST_SEL_DR: tap_next = m ? ST_SEL_IR : ST_CAP_DR;
            ST_CAP_DR: tap_next = m ? ST_EX1_DR : ST_SH_DR;
            ST_SH_DR: tap_next = m ? ST_EX1_DR : ST_SH_DR;
            ST_EX1_DR: tap_next = m ? ST_UPD_DR : ST_PA_DR;
            ST_PA_DR: tap_next = m ? ST_EX2_DR : ST_PA_DR;
            ST_EX2_DR: tap_next = m ? ST_UPD_DR : ST_SH_DR;
            ST_UPD_DR: tap_next = m ? ST_SEL_DR : ST_RTI;
            ST_SEL_IR: tap_next = m ? ST_TLR : ST_CAP_IR;
            ST_CAP_IR: tap_next = m ? ST_EX1_IR : ST_SH_IR;
            ST_SH_IR: tap_next = m ? ST_EX1_IR : ST_SH_IR;
            ST_EX1_IR: tap_next = m ? ST_UPD_IR : ST_PA_IR;
            ST_PA_IR: tap_next = m ? ST_EX2_IR : ST_PA_IR;
            ST_EX2_IR: tap_next = m ? ST_UPD_IR : ST_SH_IR;
            ST_UPD_IR: tap_next = m ? ST_SEL_DR : ST_RTI;
            default: tap_next = ST_TLR;
         endcase
      end
   endfunction

   reg [`JSC_IDX_W-1:0] a_idx_r;
   reg a_wr_r, tpd_r, pud_r, armed_r, pend_r, tprf_r, tck_d_r;
   reg byp_r, rst_sh_r, rst_reg_r, dr_so, tpd_commit;
   reg [1:0] vec_r;
   reg [`JSC_WIN_CNT_W-1:0] win_cnt_r;
   reg [`JSC_IRQ_W-1:0] irq_sts_r, irq_en_r, irq_set, irq_clr;
   reg [31:0] rd_nxt;
   reg [3:0] tap_r;
   reg [`JSC_IR_W-1:0] ir_sh_r, ir_r;
   reg [CHAIN_LEN-1:0] bs_par_in;
   integer p, k;
   wire [NPINS+3:0] lnk_s;
   wire [NPINS-1:0] pin_s;
   wire fuse_s, tck_s, tms_s, tdi_s, tck_rise, tck_fall;
   wire addr_ok, wr_act, wr_ctrl, tpd_wr, port_on, bs_sel, extest, bs_so;
   wire [CHAIN_LEN-1:0] bs_par_out;

   assign hreadyout = 1'b1;
   assign hresp = 1'b0;

   // Address phase of a NONSEQ or SEQ transfer
   assign addr_ok = hsel && hready && (htrans == `JSC_HTRANS_NONSEQ || htrans == `JSC_HTRANS_SEQ);

   // Address phase held into the data phase; test clock kept for edge finding
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         a_idx_r <= {`JSC_IDX_W{1'b0}};
         a_wr_r <= 1'b0;
         tck_d_r <= 1'b0;
      end else begin
         a_idx_r <= haddr[`JSC_IDX_W+1:2];
         a_wr_r <= addr_ok && hwrite;
         tck_d_r <= tck_s;
      end
   end

   assign wr_act = a_wr_r;
   assign wr_ctrl = wr_act && (a_idx_r == `JSC_IDX_CTRL);
   assign tpd_wr = hwdata[`JSC_CTRL_TPD];

   // timed pair: second matching write inside window commits
   always @* begin
      tpd_commit = wr_ctrl && armed_r && (win_cnt_r < `JSC_TIMED_WIN) && (pend_r == tpd_wr);
   end

   // lone or late write only re-arms, never commits
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         armed_r <= 1'b0;
         pend_r <= 1'b0;
         win_cnt_r <= {`JSC_WIN_CNT_W{1'b0}};
         tpd_r <= `JSC_CTRL_TPD_RST;
      end else if (tpd_commit) begin
         armed_r <= 1'b0;
         tpd_r <= pend_r;
      end else if (wr_ctrl) begin
         armed_r <= 1'b1;
         pend_r <= tpd_wr;
         win_cnt_r <= {`JSC_WIN_CNT_W{1'b0}};
      end else if (armed_r) begin
         win_cnt_r <= win_cnt_r + 1'b1;
         if (win_cnt_r == `JSC_TIMED_WIN - 1'b1) begin
            armed_r <= 1'b0;
         end
      end
   end

   // Plain control bits write at once
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pud_r <= 1'b0;
         vec_r <= 2'h0;
      end else if (wr_ctrl) begin
         pud_r <= hwdata[`JSC_CTRL_PUD];
         vec_r <= {hwdata[`JSC_CTRL_IVSEL], hwdata[`JSC_CTRL_IVCE]};
      end
   end

   assign vector_ctrl = vec_r;

   // port lives only with fuse set and disable clear
   assign port_on = fuse_s && !tpd_r;

   // reset request from the reset register
   assign device_reset_req = port_on && (ir_r == `JSC_IR_DEVRST) && rst_reg_r;

   // Interrupt events and software clears
   always @* begin
      irq_set = {`JSC_IRQ_W{1'b0}};
      irq_set[`JSC_IRQ_TPRF] = device_reset_req;
      irq_set[`JSC_IRQ_TPD_CHG] = tpd_commit && (pend_r != tpd_r);
      irq_clr = (wr_act && a_idx_r == `JSC_IDX_IRQ_CLR) ? hwdata[`JSC_IRQ_W-1:0] : `JSC_IRQ_RST;
   end

   // reset flag: set wins over a written zero
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         tprf_r <= 1'b0;
      end else if (device_reset_req) begin
         tprf_r <= 1'b1;
      end else if (wr_act && a_idx_r == `JSC_IDX_RSTS && !hwdata[`JSC_RSTS_TPRF]) begin
         tprf_r <= 1'b0;
      end
   end

   // Sticky status, set beats clear
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         irq_sts_r <= `JSC_IRQ_RST;
         irq_en_r <= `JSC_IRQ_RST;
      end else begin
         irq_sts_r <= (irq_sts_r & ~irq_clr) | irq_set;
         if (wr_act && a_idx_r == `JSC_IDX_IRQ_EN) begin
            irq_en_r <= hwdata[`JSC_IRQ_W-1:0];
         end
      end
   end

   assign irq = |(irq_sts_r & irq_en_r);

   // Read data prepared in the address phase; unmapped reads zero
   always @* begin
      rd_nxt = 32'h0000_0000;
      case (haddr[`JSC_IDX_W+1:2])
         `JSC_IDX_CTRL: begin
            rd_nxt[`JSC_CTRL_TPD] = tpd_r;
            rd_nxt[`JSC_CTRL_PUD] = pud_r;
            rd_nxt[`JSC_CTRL_IVSEL] = vec_r[1];
            rd_nxt[`JSC_CTRL_IVCE] = vec_r[0];
         end
         `JSC_IDX_RSTS: rd_nxt[`JSC_RSTS_TPRF] = tprf_r;
         `JSC_IDX_IRQ_STS: rd_nxt[`JSC_IRQ_W-1:0] = irq_sts_r;
         `JSC_IDX_IRQ_EN: rd_nxt[`JSC_IRQ_W-1:0] = irq_en_r;
         default: rd_nxt = 32'h0000_0000;
      endcase
   end

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= 32'h0000_0000;
      end else if (addr_ok && !hwrite) begin
         hrdata <= rd_nxt;
      end
   end

   // Link pins, fuse and pin levels cross into hclk before any use
   jsc_sync #(.W(NPINS+4)) u_sync (
      .clk(hclk),
      .rst_n(hresetn),
      .d({test_port_enable_fuse, tck, tms, tdi, pin_in}),
      .q(lnk_s)
   );

   assign fuse_s = lnk_s[NPINS+3];
   assign tck_s = lnk_s[NPINS+2];
   assign tms_s = lnk_s[NPINS+1];
   assign tdi_s = lnk_s[NPINS];
   assign pin_s = lnk_s[NPINS-1:0];

   assign tck_rise = tck_s && !tck_d_r && port_on;
   assign tck_fall = !tck_s && tck_d_r && port_on;

   // a disabled port holds its controller in reset
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         tap_r <= ST_TLR;
         ir_sh_r <= `JSC_IR_BYPASS;
         ir_r <= `JSC_IR_BYPASS;
         byp_r <= 1'b0;
         rst_sh_r <= 1'b0;
         rst_reg_r <= 1'b0;
      end else if (!port_on || (tck_rise && tap_r == ST_TLR)) begin
         tap_r <= port_on ? tap_next(tap_r, tms_s) : ST_TLR;
         ir_r <= `JSC_IR_BYPASS;
         rst_reg_r <= 1'b0;
      end else if (tck_rise) begin
         tap_r <= tap_next(tap_r, tms_s);
         case (tap_r)
            ST_CAP_IR: ir_sh_r <= `JSC_IR_CAPTURE;
            ST_SH_IR: ir_sh_r <= {tdi_s, ir_sh_r[`JSC_IR_W-1:1]};
            ST_UPD_IR: ir_r <= ir_sh_r;
            ST_CAP_DR: begin
               byp_r <= 1'b0;
               rst_sh_r <= rst_reg_r;
            end
            ST_SH_DR: begin
               byp_r <= tdi_s;
               rst_sh_r <= tdi_s;
            end
            ST_UPD_DR: begin
               if (ir_r == `JSC_IR_DEVRST) begin
                  rst_reg_r <= rst_sh_r;
               end
            end
            default: ;
         endcase
      end
   end

   assign bs_sel = (ir_r == `JSC_IR_EXTEST) || (ir_r == `JSC_IR_SAMPLE);
   assign extest = port_on && (ir_r == `JSC_IR_EXTEST);

   // three cells per pin, data highest; top cell is the edge pull-up
   always @* begin
      bs_par_in = {CHAIN_LEN{1'b0}};
      for (p = 0; p < NPINS; p = p + 1) begin
         bs_par_in[`JSC_CELLS_PER_PIN*p+`JSC_CELL_DATA] = pin_s[p];
         bs_par_in[`JSC_CELLS_PER_PIN*p+`JSC_CELL_CTRL] = core_oe[p];
         bs_par_in[`JSC_CELLS_PER_PIN*p+`JSC_CELL_PUE] = core_pue[p];
      end
      bs_par_in[CHAIN_LEN-1] = edge_core_pue;
   end

   jsc_scan_chain #(.LEN(CHAIN_LEN)) u_chain (
      .clk(hclk),
      .rst_n(hresetn),
      .capture_en(tck_rise && bs_sel && tap_r == ST_CAP_DR),
      .shift_en(tck_rise && bs_sel && tap_r == ST_SH_DR),
      .update_en(tck_rise && bs_sel && tap_r == ST_UPD_DR),
      .si(tdi_s),
      .par_in(bs_par_in),
      .so(bs_so),
      .par_out(bs_par_out)
   );

   // pins follow the update cells under external test
   always @* begin
      for (k = 0; k < NPINS; k = k + 1) begin
         pin_out[k] = extest ? bs_par_out[`JSC_CELLS_PER_PIN*k+`JSC_CELL_DATA] : core_out[k];
         pin_oe[k] = extest ? bs_par_out[`JSC_CELLS_PER_PIN*k+`JSC_CELL_CTRL] : core_oe[k];
         pin_pue[k] = extest ? bs_par_out[`JSC_CELLS_PER_PIN*k+`JSC_CELL_PUE]
                             : (core_pue[k] && !pud_r);
      end
      edge_pin_pue = extest ? bs_par_out[CHAIN_LEN-1] : (edge_core_pue && !pud_r);
   end

   always @* begin
      if (bs_sel) begin
         dr_so = bs_so;
      end else if (ir_r == `JSC_IR_DEVRST) begin
         dr_so = rst_sh_r;
      end else begin
         dr_so = byp_r;
      end
   end

   // Output bit moves on the falling test clock, as a tester expects
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         tdo <= 1'b0;
      end else if (tck_fall) begin
         tdo <= (tap_r == ST_SH_IR) ? ir_sh_r[0] : dr_so;
      end
   end

   // output released whenever the port is off, so no static drive
   assign tdo_oe = port_on && (tap_r == ST_SH_IR || tap_r == ST_SH_DR);
endmodule // jsc_top
